// *** bar0_regs_defs.svh ***
`ifndef BAR0_REGS_DEFS_SVH
`define BAR0_REGS_DEFS_SVH

// ----------------------------------------------------------------
// Address map (byte offsets inside the 4 KB window)
// ----------------------------------------------------------------
`define ADDR_W 12
`define OFS_DB_P2L 12'h000
`define OFS_DB_L2P 12'h004
`define OFS_MB_P2L 12'h100
`define OFS_MB_L2P 12'h104
`define OFS_LAT_CTRL 12'h200
`define OFS_LAT_DATA 12'h204
`define OFS_CTRL 12'h300

// ----------------------------------------------------------------
// Shared control register fields
// ----------------------------------------------------------------
`define CTRL_DB_P2L_IE 0
`define CTRL_DB_L2P_IE 1
`define CTRL_MB_P2L_IE 2
`define CTRL_MB_L2P_IE 3
`define CTRL_MB_P2L_FULL 4
`define CTRL_MB_L2P_FULL 5
`define CTRL_IE_W 4
`define CTRL_IE_RST 4'h0

// ----------------------------------------------------------------
// Latency timing, in PCI clocks
// ----------------------------------------------------------------
`define LAT_W 4
`define LAT_BOUND_CLKS 16
`define LAT_OVERHEAD_CLKS 4
`define LAT_MAX_WAIT (`LAT_BOUND_CLKS - `LAT_OVERHEAD_CLKS)
`define LAT_RST 4'h0

`endif

// *** bar0_regs_pkg.sv ***
package bar0_regs_pkg;

  // PCI-side request, held by the target core for one cycle
  typedef struct packed {
    logic we;
    logic [11:0] addr;
    logic [31:0] wdata;
  } pci_req_t;

  // PCI-side completion
  typedef struct packed {
    logic done;
    logic stop;
    logic [31:0] rdata;
  } pci_rsp_t;

  // Register selected by an address
  typedef enum {
    SEL_DB_P2L,
    SEL_DB_L2P,
    SEL_MB_P2L,
    SEL_MB_L2P,
    SEL_LAT_CTRL,
    SEL_LAT_DATA,
    SEL_CTRL,
    SEL_NONE
  } reg_sel_t;

  // Access sequencer states
  typedef enum {
    ST_IDLE,
    ST_WAIT
  } acc_state_t;

endpackage

// *** pci_bar0_doorbell_mailbox_regs.sv ***
`timescale 1ns/10ps
`include "bar0_regs_defs.svh"

// Function
// - Decode a 4 KB memory space onto the block's registers.
// - No bursts; every access ends with disconnect carrying data.
// - Space split into doorbell, mailbox, latency and control regions.
// - PCI writing one to a PCI-to-local doorbell bit sets it, interrupting local.
// - Doorbell reads from either side return bits and change nothing.
// - Recipient clears doorbell bits by writing ones; zeros leave bits alone.
// - Mirror local-to-PCI doorbell; setter can never clear its bits.
// - Doorbell interrupt only while its enable bit is set.
// - PCI write to empty PCI-to-local mailbox stores data, sets full.
// - Sender writes to a full mailbox are ignored entirely.
// - Sender reading mailbox gets full flag replicated across all bits.
// - Receiver reading mailbox gets data and clears full flag.
// - Receiver reading empty mailbox gets last delivered data.
// - Second mailbox: local sends, PCI receives, same behaviour.
// - Both full flags readable in control register from both sides.
// - Full mailbox interrupts receiver only; cleared by receiver read.
// - Mailbox interrupt only while its enable bit is set.
// - Latency registers complete single beat within 16 clocks of frame.
// - Latency control keeps four bits setting latency of both registers.
// - Latency control PCI only; local reads zero, writes ignored.
// - Latency data is PCI-only scratch register; local sees zeros.
// - All logic on PCI clock; local port has enables, address, data.
// - Local doorbell and mailbox interrupts on one active-low output.
module pci_bar0_doorbell_mailbox_regs
  import bar0_regs_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // PCI target core side
  input wire logic i_pci_req,
  input wire pci_req_t i_pci_cmd,
  output pci_rsp_t o_pci_rsp,
  output logic o_pci_irq,
  // Local register port
  input wire logic i_local_reg_write_en,
  input wire logic i_local_reg_read_en,
  input wire logic [`ADDR_W-1:0] i_local_reg_addr,
  input wire logic [31:0] i_local_reg_wdata,
  output logic [31:0] o_local_reg_rdata,
  output logic o_local_irq_n
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------

  // Word compare only; the byte lane bits are ignored
  function automatic reg_sel_t decode(input logic [`ADDR_W-1:0] a);
    logic [`ADDR_W-1:0] w;
    w = {a[`ADDR_W-1:2], 2'b00};
    case (w)
      `OFS_DB_P2L: decode = SEL_DB_P2L;
      `OFS_DB_L2P: decode = SEL_DB_L2P;
      `OFS_MB_P2L: decode = SEL_MB_P2L;
      `OFS_MB_L2P: decode = SEL_MB_L2P;
      `OFS_LAT_CTRL: decode = SEL_LAT_CTRL;
      `OFS_LAT_DATA: decode = SEL_LAT_DATA;
      `OFS_CTRL: decode = SEL_CTRL;
      default: decode = SEL_NONE;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  acc_state_t state_r;
  pci_req_t req_r;
  logic [`LAT_W-1:0] wait_cnt_r;
  logic [31:0] db_p2l_r;
  logic [31:0] db_l2p_r;
  logic [31:0] mb_p2l_r;
  logic [31:0] mb_l2p_r;
  logic mb_p2l_full_r;
  logic mb_l2p_full_r;
  logic [`CTRL_IE_W-1:0] ie_r;
  logic [`LAT_W-1:0] lat_ctrl_r;
  logic [31:0] lat_data_r;
  logic [`LAT_W-1:0] lat_wait;
  logic [31:0] ctrl_word;
  logic [31:0] pci_rd_mux;
  logic [31:0] loc_rd_mux;
  reg_sel_t psel;
  reg_sel_t lsel;
  reg_sel_t nsel;
  logic pci_acc;
  logic pci_wr;
  logic pci_rd;
  logic loc_wr;
  logic loc_rd;
  logic [31:0] db_p2l_set;
  logic [31:0] db_p2l_clr;
  logic [31:0] db_l2p_set;
  logic [31:0] db_l2p_clr;

  // ----------------------------------------------------------------
  // Strobes
  // ----------------------------------------------------------------

  // One access strobe per PCI request, at the end of its wait states
  assign pci_acc = (state_r == ST_WAIT) && (wait_cnt_r == '0);
  assign pci_wr = pci_acc && req_r.we;
  assign pci_rd = pci_acc && !req_r.we;
  assign psel = decode(req_r.addr);
  assign nsel = decode(i_pci_cmd.addr);
  assign lsel = decode(i_local_reg_addr);
  assign loc_wr = i_local_reg_write_en;
  assign loc_rd = i_local_reg_read_en;

  // Wait states for the latency region, clipped to keep the bound
  assign lat_wait = (lat_ctrl_r > `LAT_W'(`LAT_MAX_WAIT)) ? `LAT_W'(`LAT_MAX_WAIT) : lat_ctrl_r;

  // ----------------------------------------------------------------
  // PCI access sequencer
  // ----------------------------------------------------------------

  // Request captured in idle; requests while busy are not expected
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= ST_IDLE;
      req_r <= '0;
      wait_cnt_r <= '0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (i_pci_req) begin
            req_r <= i_pci_cmd;
            state_r <= ST_WAIT;
            if (nsel == SEL_LAT_CTRL || nsel == SEL_LAT_DATA) begin
              wait_cnt_r <= lat_wait;
            end else begin
              wait_cnt_r <= '0;
            end
          end
        end
        ST_WAIT: begin
          if (wait_cnt_r == '0) begin
            state_r <= ST_IDLE;
          end else begin
            wait_cnt_r <= wait_cnt_r - `LAT_W'(1);
          end
        end
      endcase
    end
  end

  // Completion: single beat, always disconnect with data
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pci_rsp <= '0;
    end else begin
      o_pci_rsp.done <= pci_acc;
      o_pci_rsp.stop <= pci_acc;
      if (pci_rd) begin
        o_pci_rsp.rdata <= pci_rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Doorbells
  // ----------------------------------------------------------------

  // Only the setter can set, only the recipient can clear
  assign db_p2l_set = (pci_wr && psel == SEL_DB_P2L) ? req_r.wdata : '0;
  assign db_p2l_clr = (loc_wr && lsel == SEL_DB_P2L) ? i_local_reg_wdata : '0;
  assign db_l2p_set = (loc_wr && lsel == SEL_DB_L2P) ? i_local_reg_wdata : '0;
  assign db_l2p_clr = (pci_wr && psel == SEL_DB_L2P) ? req_r.wdata : '0;

  // Set wins over a clear in the same cycle so no ring is lost
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      db_p2l_r <= '0;
      db_l2p_r <= '0;
    end else begin
      db_p2l_r <= (db_p2l_r & ~db_p2l_clr) | db_p2l_set;
      db_l2p_r <= (db_l2p_r & ~db_l2p_clr) | db_l2p_set;
    end
  end

  // ----------------------------------------------------------------
  // Mailboxes
  // ----------------------------------------------------------------

  // Data held after the flag clears, so an empty read sees the last mail
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mb_p2l_r <= '0;
      mb_l2p_r <= '0;
    end else begin
      if (pci_wr && psel == SEL_MB_P2L && !mb_p2l_full_r) begin
        mb_p2l_r <= req_r.wdata;
      end
      if (loc_wr && lsel == SEL_MB_L2P && !mb_l2p_full_r) begin
        mb_l2p_r <= i_local_reg_wdata;
      end
    end
  end

  // Full flags: a real delivery beats a same-cycle pickup; a write to a full box is no delivery
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mb_p2l_full_r <= 1'b0;
      mb_l2p_full_r <= 1'b0;
    end else begin
      if (pci_wr && psel == SEL_MB_P2L && !mb_p2l_full_r) begin
        mb_p2l_full_r <= 1'b1;
      end else if (loc_rd && lsel == SEL_MB_P2L) begin
        mb_p2l_full_r <= 1'b0;
      end
      if (loc_wr && lsel == SEL_MB_L2P && !mb_l2p_full_r) begin
        mb_l2p_full_r <= 1'b1;
      end else if (pci_rd && psel == SEL_MB_L2P) begin
        mb_l2p_full_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control and latency registers
  // ----------------------------------------------------------------

  // Enables writable from both sides; PCI wins a same-cycle collision
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ie_r <= `CTRL_IE_RST;
    end else if (pci_wr && psel == SEL_CTRL) begin
      ie_r <= req_r.wdata[`CTRL_IE_W-1:0];
    end else if (loc_wr && lsel == SEL_CTRL) begin
      ie_r <= i_local_reg_wdata[`CTRL_IE_W-1:0];
    end
  end

  // PCI only; the local port cannot reach either register
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lat_ctrl_r <= `LAT_RST;
      lat_data_r <= '0;
    end else begin
      if (pci_wr && psel == SEL_LAT_CTRL) begin
        lat_ctrl_r <= req_r.wdata[`LAT_W-1:0];
      end
      if (pci_wr && psel == SEL_LAT_DATA) begin
        lat_data_r <= req_r.wdata;
      end
    end
  end

  // Full flags always visible to both sides
  assign ctrl_word = {26'h0, mb_l2p_full_r, mb_p2l_full_r, ie_r};

  // ----------------------------------------------------------------
  // Read paths
  // ----------------------------------------------------------------

  // PCI read data; doorbell reads have no side effect
  always_comb begin
    pci_rd_mux = '0;
    unique case (psel)
      SEL_DB_P2L: pci_rd_mux = db_p2l_r;
      SEL_DB_L2P: pci_rd_mux = db_l2p_r;
      SEL_MB_P2L: pci_rd_mux = {32{mb_p2l_full_r}};
      SEL_MB_L2P: pci_rd_mux = mb_l2p_r;
      SEL_LAT_CTRL: pci_rd_mux = {28'h0, lat_ctrl_r};
      SEL_LAT_DATA: pci_rd_mux = lat_data_r;
      SEL_CTRL: pci_rd_mux = ctrl_word;
      SEL_NONE: pci_rd_mux = '0;
    endcase
  end

  // Local read data; latency registers read as zero
  always_comb begin
    loc_rd_mux = '0;
    unique case (lsel)
      SEL_DB_P2L: loc_rd_mux = db_p2l_r;
      SEL_DB_L2P: loc_rd_mux = db_l2p_r;
      SEL_MB_P2L: loc_rd_mux = mb_p2l_r;
      SEL_MB_L2P: loc_rd_mux = {32{mb_l2p_full_r}};
      SEL_LAT_CTRL: loc_rd_mux = '0;
      SEL_LAT_DATA: loc_rd_mux = '0;
      SEL_CTRL: loc_rd_mux = ctrl_word;
      SEL_NONE: loc_rd_mux = '0;
    endcase
  end

  // Local data registered one cycle after the read enable
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_local_reg_rdata <= '0;
    end else if (loc_rd) begin
      o_local_reg_rdata <= loc_rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------

  // Each side sees only the events addressed to it
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_local_irq_n <= 1'b1;
      o_pci_irq <= 1'b0;
    end else begin
      o_local_irq_n <= !((ie_r[`CTRL_DB_P2L_IE] && (|db_p2l_r)) ||
                         (ie_r[`CTRL_MB_P2L_IE] && mb_p2l_full_r));
      o_pci_irq <= (ie_r[`CTRL_DB_L2P_IE] && (|db_l2p_r)) ||
                   (ie_r[`CTRL_MB_L2P_IE] && mb_l2p_full_r);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  property p_fast_done;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (i_pci_req && state_r == ST_IDLE && nsel != SEL_LAT_CTRL && nsel != SEL_LAT_DATA)
      |-> ##1 !o_pci_rsp.done ##1 (o_pci_rsp.done && o_pci_rsp.stop);
  endproperty
  a_fast_done: assert property (p_fast_done) else $error("plain access not done in two cycles");

  property p_bounded;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (i_pci_req && state_r == ST_IDLE) |-> ##[2:14] o_pci_rsp.done;
  endproperty
  a_bounded: assert property (p_bounded) else $error("access exceeded latency bound");

  property p_db_set;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (pci_wr && psel == SEL_DB_P2L) |=> ((db_p2l_r & $past(req_r.wdata)) == $past(req_r.wdata));
  endproperty
  a_db_set: assert property (p_db_set) else $error("doorbell bit not set");

  property p_db_setter_no_clear;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (!(loc_wr && lsel == SEL_DB_P2L)) |=> (($past(db_p2l_r) & ~db_p2l_r) == '0);
  endproperty
  a_db_setter_no_clear: assert property (p_db_setter_no_clear) else $error("doorbell cleared by setter");

  property p_mb_ignore;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (pci_wr && psel == SEL_MB_P2L && mb_p2l_full_r && !(loc_rd && lsel == SEL_MB_P2L))
      |=> ($stable(mb_p2l_r) && mb_p2l_full_r);
  endproperty
  a_mb_ignore: assert property (p_mb_ignore) else $error("write to full mailbox took effect");

  property p_mb_pickup;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (loc_rd && lsel == SEL_MB_P2L && !(pci_wr && psel == SEL_MB_P2L))
      |=> (!mb_p2l_full_r && o_local_reg_rdata == $past(mb_p2l_r));
  endproperty
  a_mb_pickup: assert property (p_mb_pickup) else $error("mailbox pickup wrong");

  property p_mb_sender_read;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (pci_rd && psel == SEL_MB_P2L) |=> (o_pci_rsp.rdata == {32{$past(mb_p2l_full_r)}});
  endproperty
  a_mb_sender_read: assert property (p_mb_sender_read) else $error("sender read not full flag");

  property p_irq_masked;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (!ie_r[`CTRL_DB_P2L_IE] && !ie_r[`CTRL_MB_P2L_IE]) |=> o_local_irq_n;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("local interrupt while disabled");

  property p_local_lat_zero;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (loc_rd && (lsel == SEL_LAT_CTRL || lsel == SEL_LAT_DATA)) |=> (o_local_reg_rdata == '0);
  endproperty
  a_local_lat_zero: assert property (p_local_lat_zero) else $error("local saw latency register");

endmodule // pci_bar0_doorbell_mailbox_regs

// *** pci_core_model.sv ***
`timescale 1ns/10ps
// ----------------------------------------------------------------
// PCI target core stand-in
// ----------------------------------------------------------------
module pci_core_model
  import bar0_regs_pkg::*;
(
  // Clock
  input wire logic i_sys_clk,
  // Request toward the register block
  output logic o_pci_req,
  output pci_req_t o_pci_cmd,
  // Completion from the register block
  input wire pci_rsp_t i_pci_rsp
);
  // Idle bus at time zero
  initial begin
    o_pci_req = 1'b0;
    o_pci_cmd = '0;
  end

  // One single-beat access; cycles counted from the take edge, 99 on timeout
  task automatic access(input logic we, input logic [11:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output int cycles, output logic stop);
    logic got;
    got = 1'b0;
    cycles = 0;
    rdata = '0;
    stop = 1'b0;
    @(posedge i_sys_clk);
    o_pci_req <= 1'b1; // Never more than one data phase
    o_pci_cmd <= pci_req_t'({we, addr, wdata});
    @(posedge i_sys_clk);
    o_pci_req <= 1'b0;
    // Released lines must not keep looking valid
    o_pci_cmd <= pci_req_t'(~{we, addr, wdata});
    while (!got && cycles < 20) begin
      @(posedge i_sys_clk);
      #1;
      cycles++;
      if (i_pci_rsp.done === 1'b1) begin
        got = 1'b1;
        // Seen just after its launching edge; sampled high at the next edge
        cycles++;
        rdata = i_pci_rsp.rdata;
        stop = i_pci_rsp.stop;
      end
    end
    if (!got) begin
      cycles = 99;
    end
  endtask
endmodule // pci_core_model

// *** tb_pci_bar0_doorbell_mailbox_regs.sv ***
`timescale 1ns/10ps
`include "bar0_regs_defs.svh"
module tb_pci_bar0_doorbell_mailbox_regs
  import bar0_regs_pkg::*;
();
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic i_sys_clk;
  logic i_rst_b;
  logic pci_req;
  pci_req_t pci_cmd;
  pci_rsp_t pci_rsp;
  logic pci_irq;
  logic local_reg_write_en;
  logic local_reg_read_en;
  logic [11:0] local_reg_addr;
  logic [31:0] lwdata;
  logic [31:0] lrdata;
  logic lirq_n;
  logic [31:0] rd;
  int bad_count;
  int comparisons;
  int cur;
  int lats[4] = '{0, 5, 12, 15};

  pci_bar0_doorbell_mailbox_regs i_pci_bar0_doorbell_mailbox_regs (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_pci_req(pci_req), .i_pci_cmd(pci_cmd),
    .o_pci_rsp(pci_rsp), .o_pci_irq(pci_irq), .i_local_reg_write_en(local_reg_write_en),
    .i_local_reg_read_en(local_reg_read_en), .i_local_reg_addr(local_reg_addr), .i_local_reg_wdata(lwdata),
    .o_local_reg_rdata(lrdata), .o_local_irq_n(lirq_n));

  pci_core_model i_pci_core_model (
    .i_sys_clk(i_sys_clk), .o_pci_req(pci_req), .o_pci_cmd(pci_cmd), .i_pci_rsp(pci_rsp));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic int lat_cyc(input int v);
    return 2 + ((v > 12) ? 12 : v);
  endfunction

  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic results();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // PCI access with completion time and disconnect check; a hang ends the run
  task automatic pci(input logic we, input logic [11:0] a, input logic [31:0] wd, input int ecyc,
                     output logic [31:0] r);
    int n;
    logic s;
    i_pci_core_model.access(we, a, wd, r, n, s);
    chk("pci completion cycles", 32'(n), 32'(ecyc));
    chk("pci stop with done", {31'h0, s}, 32'h1);
    if (n == 99) begin
      results();
    end
  endtask

  task automatic pchk(input string name, input logic [11:0] a, input logic [31:0] exp, input int ecyc);
    logic [31:0] r;
    pci(1'b0, a, 32'h0, ecyc, r);
    chk(name, r, exp);
  endtask

  task automatic lwr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    local_reg_write_en <= 1'b1;
    local_reg_addr <= a;
    lwdata <= d;
    @(posedge i_sys_clk);
    local_reg_write_en <= 1'b0;
    lwdata <= ~d;
  endtask

  // Local read; data is registered at the enable edge
  task automatic lchk(input string name, input logic [11:0] a, input logic [31:0] exp);
    @(posedge i_sys_clk);
    local_reg_read_en <= 1'b1;
    local_reg_addr <= a;
    @(posedge i_sys_clk);
    local_reg_read_en <= 1'b0;
    #1;
    chk(name, lrdata, exp);
  endtask

  // Interrupt outputs lag the state by one cycle
  task automatic irqs(input logic exp_n, input logic exp_p);
    repeat (2) @(posedge i_sys_clk);
    #1;
    chk("local irq_n", {31'h0, lirq_n}, {31'h0, exp_n});
    chk("pci irq", {31'h0, pci_irq}, {31'h0, exp_p});
  endtask

  // ----------------------------------------------------------------
  // Clock, reset and sequence
  // ----------------------------------------------------------------
  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end

  initial begin
    i_rst_b = 1'b0;
    local_reg_write_en = 1'b0;
    local_reg_read_en = 1'b0;
    local_reg_addr = '0;
    lwdata = '0;
    bad_count = 0;
    comparisons = 0;
    cur = 0;
    repeat (10) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    irqs(1'b1, 1'b0);
    lchk("ctrl at reset", `OFS_CTRL, 32'h0);
    // Doorbell toward local, first with its enable off
    pci(1'b1, `OFS_DB_P2L, 32'h81, 2, rd);
    irqs(1'b1, 1'b0);
    pci(1'b1, `OFS_CTRL, 32'hF, 2, rd);
    irqs(1'b0, 1'b0);
    lchk("db p2l local", `OFS_DB_P2L, 32'h81);
    pchk("db p2l pci", `OFS_DB_P2L, 32'h81, 2);
    pci(1'b1, `OFS_DB_P2L, 32'h01, 2, rd);
    lchk("db p2l setter write", `OFS_DB_P2L, 32'h81);
    lwr(`OFS_DB_P2L, 32'h01);
    lchk("db p2l cleared", `OFS_DB_P2L, 32'h80);
    lwr(`OFS_DB_P2L, 32'h80);
    irqs(1'b1, 1'b0);
    // Doorbell toward PCI
    lwr(`OFS_DB_L2P, 32'h3C);
    irqs(1'b1, 1'b1);
    lwr(`OFS_DB_L2P, 32'h0);
    pchk("db l2p", `OFS_DB_L2P, 32'h3C, 2);
    pci(1'b1, `OFS_DB_L2P, 32'h0C, 2, rd);
    lchk("db l2p cleared", `OFS_DB_L2P, 32'h30);
    pci(1'b1, `OFS_DB_L2P, 32'h30, 2, rd);
    // Mailbox toward local
    pci(1'b1, `OFS_MB_P2L, 32'h1234_5678, 2, rd);
    pchk("mb p2l sender", `OFS_MB_P2L, 32'hFFFF_FFFF, 2);
    lchk("ctrl p2l full", `OFS_CTRL, 32'h1F);
    irqs(1'b0, 1'b0);
    pci(1'b1, `OFS_MB_P2L, 32'hDEAD_BEEF, 2, rd);
    lchk("mb p2l pickup", `OFS_MB_P2L, 32'h1234_5678);
    irqs(1'b1, 1'b0);
    pchk("mb p2l empty", `OFS_MB_P2L, 32'h0, 2);
    lchk("mb p2l reread", `OFS_MB_P2L, 32'h1234_5678);
    // Mailbox toward PCI
    lwr(`OFS_MB_L2P, 32'hA5A5_0F0F);
    lchk("mb l2p sender", `OFS_MB_L2P, 32'hFFFF_FFFF);
    pchk("ctrl l2p full", `OFS_CTRL, 32'h2F, 2);
    irqs(1'b1, 1'b1);
    lwr(`OFS_MB_L2P, 32'h1111_1111);
    pchk("mb l2p pickup", `OFS_MB_L2P, 32'hA5A5_0F0F, 2);
    irqs(1'b1, 1'b0);
    pchk("mb l2p reread", `OFS_MB_L2P, 32'hA5A5_0F0F, 2);
    // Mailbox interrupt masked
    pci(1'b1, `OFS_CTRL, 32'hB, 2, rd);
    pci(1'b1, `OFS_MB_P2L, 32'h55, 2, rd);
    irqs(1'b1, 1'b0);
    lchk("mb p2l masked", `OFS_MB_P2L, 32'h55);
    // Latency pair; a write completes with the old setting
    foreach (lats[i]) begin
      pci(1'b1, `OFS_LAT_CTRL, {28'hFFF_FFFF, 4'(lats[i])}, lat_cyc(cur), rd);
      cur = lats[i];
      pchk("lat ctrl", `OFS_LAT_CTRL, {28'h0, 4'(lats[i])}, lat_cyc(cur));
      pci(1'b1, `OFS_LAT_DATA, 32'h600D_0000 + 32'(cur), lat_cyc(cur), rd);
      pchk("lat data", `OFS_LAT_DATA, 32'h600D_0000 + 32'(cur), lat_cyc(cur));
    end
    lwr(`OFS_LAT_CTRL, 32'h0);
    lwr(`OFS_LAT_DATA, 32'h0);
    lchk("lat ctrl local", `OFS_LAT_CTRL, 32'h0);
    lchk("lat data local", `OFS_LAT_DATA, 32'h0);
    pchk("lat ctrl kept", `OFS_LAT_CTRL, 32'hF, 14);
    pchk("lat data kept", `OFS_LAT_DATA, 32'h600D_000F, 14);
    // Unmapped places inside the window
    pchk("unmapped pci", 12'h080, 32'h0, 2);
    lchk("unmapped local", 12'h080, 32'h0);
    results();
  end
endmodule // tb_pci_bar0_doorbell_mailbox_regs
